// File: core/rfc_counter.sv
// Reciprocal frequency counter with decimal divider and APB registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`include "rfc_map.svh"
module rfc_counter #(
    parameter logic [20:0] CAP_TICKS  = 21'(`RFC_TICKS(`RFC_CAP_US)),
    parameter logic [20:0] MIN1_TICKS = 21'(`RFC_TICKS(`RFC_MIN1_US)),
    parameter logic [20:0] MIN2_TICKS = 21'(`RFC_TICKS(`RFC_MIN2_US)),
    parameter logic [20:0] MIN3_TICKS = 21'(`RFC_TICKS(`RFC_MIN3_US)),
    parameter logic [20:0] MIN4_TICKS = 21'(`RFC_TICKS(`RFC_MIN4_US)),
    parameter logic [20:0] RET_TICKS  = 21'(`RFC_RET_TICKS),
    parameter logic [20:0] UNIT_CYC   = 21'(`RFC_UNIT_CYC)
) (
    // Clock, reset, enable
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ce,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Conditioned signal and programming pins
    input  wire logic           sig_in,
    input  wire logic           prog_en,
    input  wire logic [1:0]     prog_tb_sel,
    input  wire logic           prog_slope,
    input  wire logic [1:0]     prog_mult,
    input  wire logic           prog_hold_inf,
    // Display and data port
    output rfc_pkg::rfc_result_t disp,
    output logic                res_valid,
    output logic                rec_strobe,
    output logic                slow_active,
    output logic                under_range
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rfc_pkg::rfc_ctrl_t  ctrl_reg;
    rfc_pkg::rfc_ctrl_t  ctrl;
    rfc_pkg::rfc_state_t st_reg;
    logic [7:0]  pin_s1_reg;
    logic [7:0]  pin_s2_reg;
    logic        sig_d_reg;
    logic [7:0]  tb_cnt_reg;
    logic [26:0] cnt_a_reg;
    logic [20:0] cnt_b_reg;
    logic [20:0] first_reg;
    logic [3:0]  digit_reg;
    logic [3:0]  norm_reg;
    logic [3:0]  rnd_reg;
    logic [2:0]  sig_cnt_reg;
    logic [23:0] quot_reg;
    logic [3:0]  dp_reg;
    logic [1:0]  units_reg;
    logic [20:0] hold_cyc_reg;
    logic [10:0] hold_units_reg;
    logic        auto_slow_reg;
    logic        slow_run_reg;
    logic        started_reg;
    logic        valid_reg;
    logic        strobe_reg;
    logic        under_reg;
    logic        slow_out_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        slow;
    logic        sig_edge;
    logic        tick;
    logic        over;
    logic        term;
    logic        rec;
    logic        last;
    logic        hold_done;
    logic        carry;
    logic [26:0] diff;
    logic [20:0] min_ticks;
    logic [20:0] fp_ticks;
    logic [10:0] disp_eff;
    logic [24:0] inc;
    logic signed [5:0] pw;
    logic [3:0]  dp_next;
    logic [1:0]  units_next;

    function automatic logic [24:0] bcd_inc(input logic [23:0] q);
        logic [24:0] r;
        logic        c;
        r = 25'h0000000;
        c = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (c && q[4*i +: 4] == 4'h9) begin
                r[4*i +: 4] = 4'h0;
            end else begin
                r[4*i +: 4] = q[4*i +: 4] + {3'b000, c};
                c = 1'b0;
            end
        end
        r[24] = c;
        return r;
    endfunction : bcd_inc

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
            sig_d_reg  <= 1'b0;
        end else if (ce) begin
            pin_s1_reg <= {sig_in, prog_en, prog_tb_sel, prog_slope,
                           prog_mult, prog_hold_inf};
            pin_s2_reg <= pin_s1_reg;
            sig_d_reg  <= pin_s2_reg[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective controls, edge and timebase
    always_comb begin
        ctrl = ctrl_reg;
        if (pin_s2_reg[6]) begin
            ctrl.tb_sel   = rfc_pkg::rfc_tb_sel_t'(pin_s2_reg[5:4]);
            ctrl.slope    = pin_s2_reg[3];
            ctrl.mult     = rfc_pkg::rfc_mult_t'(pin_s2_reg[2:1]);
            ctrl.hold_inf = pin_s2_reg[0];
        end
    end

    // Slope high selects the falling crossing
    assign sig_edge = ctrl.slope ? (sig_d_reg & ~pin_s2_reg[7])
                                 : (~sig_d_reg & pin_s2_reg[7]);

    always_comb begin
        unique case (ctrl.tb_sel)
            rfc_pkg::RFC_TB_SLOW: slow = 1'b1;
            rfc_pkg::RFC_TB_FAST: slow = 1'b0;
            default:              slow = auto_slow_reg;
        endcase
    end

    assign tick = tb_cnt_reg >= (slow ? 8'(`RFC_SLOW_DIV - 1)
                                      : 8'(`RFC_FAST_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_reg <= 8'h00;
        end else if (ce) begin
            if (st_reg != rfc_pkg::RFC_COUNT || tick) begin
                tb_cnt_reg <= 8'h00;
            end else begin
                tb_cnt_reg <= tb_cnt_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement end decision
    always_comb begin
        if (cnt_a_reg == 27'd0) begin
            min_ticks = MIN1_TICKS;
        end else if (cnt_a_reg == 27'd1) begin
            min_ticks = MIN2_TICKS;
        end else if (cnt_a_reg == 27'd2) begin
            min_ticks = MIN3_TICKS;
        end else begin
            min_ticks = MIN4_TICKS;
        end
    end

    assign over = st_reg == rfc_pkg::RFC_COUNT && tick
                  && cnt_b_reg == CAP_TICKS;
    assign term = st_reg == rfc_pkg::RFC_COUNT && sig_edge && !over
                  && cnt_b_reg >= min_ticks;
    assign fp_ticks = (cnt_a_reg == 27'd0) ? cnt_b_reg : first_reg;
    assign diff = cnt_a_reg - {6'h00, cnt_b_reg};
    assign rec  = started_reg || digit_reg != 4'h0;
    assign last = (rec && sig_cnt_reg == `RFC_LAST_SIG)
                  || (!rec && norm_reg == `RFC_NORM_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and dual-purpose registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg    <= rfc_pkg::RFC_IDLE;
            cnt_a_reg <= 27'h0;
            cnt_b_reg <= 21'h0;
            first_reg <= 21'h0;
        end else if (ce) begin
            unique case (st_reg)
                rfc_pkg::RFC_IDLE: begin
                    cnt_a_reg <= 27'h0;
                    cnt_b_reg <= 21'h0;
                    st_reg    <= rfc_pkg::RFC_ARM;
                end
                rfc_pkg::RFC_ARM: begin
                    if (sig_edge) begin
                        st_reg <= rfc_pkg::RFC_COUNT;
                    end
                end
                rfc_pkg::RFC_COUNT: begin
                    if (tick && !over) begin
                        cnt_b_reg <= cnt_b_reg + 21'h1;
                    end
                    if (sig_edge) begin
                        cnt_a_reg <= cnt_a_reg + 27'h1;
                        if (cnt_a_reg == 27'd0) begin
                            first_reg <= cnt_b_reg;
                        end
                    end
                    if (over) begin
                        st_reg <= rfc_pkg::RFC_IDLE;
                    end else if (term) begin
                        st_reg <= rfc_pkg::RFC_SUB;
                    end
                end
                rfc_pkg::RFC_SUB: begin
                    cnt_a_reg <= diff;
                    if (diff[26]) begin
                        st_reg <= rfc_pkg::RFC_ADD;
                    end
                end
                rfc_pkg::RFC_ADD: begin
                    cnt_a_reg <= cnt_a_reg + {6'h00, cnt_b_reg};
                    st_reg    <= rfc_pkg::RFC_MUL;
                end
                rfc_pkg::RFC_MUL: begin
                    cnt_a_reg <= (cnt_a_reg << 3) + (cnt_a_reg << 1);
                    st_reg <= last ? rfc_pkg::RFC_ROUND : rfc_pkg::RFC_SUB;
                end
                rfc_pkg::RFC_ROUND: begin
                    st_reg <= rfc_pkg::RFC_HOLD;
                end
                rfc_pkg::RFC_HOLD: begin
                    if (hold_done) begin
                        st_reg <= rfc_pkg::RFC_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Quotient decades and normalisation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quot_reg    <= 24'h000000;
            digit_reg   <= 4'h0;
            norm_reg    <= 4'h0;
            rnd_reg     <= 4'h0;
            sig_cnt_reg <= 3'h0;
            started_reg <= 1'b0;
            slow_run_reg <= 1'b0;
        end else if (ce) begin
            if (term) begin
                quot_reg     <= 24'h000000;
                digit_reg    <= 4'h0;
                norm_reg     <= 4'h0;
                rnd_reg      <= 4'h0;
                sig_cnt_reg  <= 3'h0;
                started_reg  <= 1'b0;
                slow_run_reg <= slow;
            end else if (st_reg == rfc_pkg::RFC_SUB && !diff[26]) begin
                digit_reg <= digit_reg + 4'h1;
            end else if (st_reg == rfc_pkg::RFC_MUL) begin
                digit_reg <= 4'h0;
                if (!rec) begin
                    norm_reg <= norm_reg + 4'h1;
                end else begin
                    started_reg <= 1'b1;
                    sig_cnt_reg <= sig_cnt_reg + 3'h1;
                    if (sig_cnt_reg == `RFC_LAST_SIG) begin
                        rnd_reg <= digit_reg;
                    end else begin
                        quot_reg <= {quot_reg[19:0], digit_reg};
                    end
                end
            end else if (st_reg == rfc_pkg::RFC_ROUND
                         && rnd_reg >= `RFC_ROUND_AT) begin
                quot_reg <= carry ? 24'h100000 : inc[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Range from the division result
    assign inc   = bcd_inc(quot_reg);
    assign carry = rnd_reg >= `RFC_ROUND_AT && inc[24];

    always_comb begin
        pw = (slow_run_reg ? 6'sd6 : 6'sd7) - $signed({2'b00, norm_reg})
             + $signed({5'b00000, carry});
        unique case (ctrl.mult)
            rfc_pkg::RFC_X10:  pw = pw + 6'sd1;
            rfc_pkg::RFC_X100: pw = pw + 6'sd2;
            default:           pw = pw;
        endcase
        if (pw >= 6'sd6) begin
            units_next = 2'd2;
            dp_next    = 4'(pw - 6'sd5);
        end else if (pw >= 6'sd3) begin
            units_next = 2'd1;
            dp_next    = 4'(pw - 6'sd2);
        end else begin
            units_next = 2'd0;
            dp_next    = (pw < -6'sd1) ? 4'h0 : 4'(pw + 6'sd1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result flags, timebase choice and display hold
    assign disp_eff = (ctrl.disp_units < `RFC_DISP_MIN) ? `RFC_DISP_MIN :
                      (ctrl.disp_units > `RFC_DISP_MAX) ? `RFC_DISP_MAX :
                      ctrl.disp_units;
    assign hold_done = !ctrl.hold_inf && hold_cyc_reg == UNIT_CYC - 21'h1
                       && hold_units_reg == disp_eff - 11'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_reg        <= 4'h0;
            units_reg     <= 2'h0;
            valid_reg     <= 1'b0;
            strobe_reg    <= 1'b0;
            under_reg     <= 1'b0;
            auto_slow_reg <= 1'b0;
            slow_out_reg  <= 1'b0;
        end else if (ce) begin
            strobe_reg   <= st_reg == rfc_pkg::RFC_ROUND;
            slow_out_reg <= slow;
            if (st_reg == rfc_pkg::RFC_ROUND) begin
                dp_reg    <= dp_next;
                units_reg <= units_next;
                valid_reg <= 1'b1;
            end else if (term) begin
                valid_reg <= 1'b0;
            end
            if (over) begin
                under_reg <= 1'b1;
            end else if (term) begin
                under_reg <= 1'b0;
            end
            if (ctrl.tb_sel == rfc_pkg::RFC_TB_AUTO) begin
                if (over && !slow) begin
                    auto_slow_reg <= 1'b1;
                end else if (term && slow && fp_ticks <= RET_TICKS) begin
                    auto_slow_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cyc_reg   <= 21'h0;
            hold_units_reg <= 11'h0;
        end else if (ce) begin
            if (st_reg != rfc_pkg::RFC_HOLD || ctrl.hold_inf) begin
                hold_cyc_reg   <= 21'h0;
                hold_units_reg <= 11'h0;
            end else if (hold_cyc_reg == UNIT_CYC - 21'h1) begin
                hold_cyc_reg   <= 21'h0;
                hold_units_reg <= hold_units_reg + 11'h1;
            end else begin
                hold_cyc_reg <= hold_cyc_reg + 21'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= rfc_pkg::rfc_ctrl_t'(`RFC_CTRL_RST);
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= psel && !penable;
            if (psel && !penable) begin
                pslverr_reg <= 1'b0;
                prdata_reg  <= 32'h0;
                if (paddr == `RFC_CTRL_OFF) begin
                    prdata_reg <= {15'h0, ctrl_reg};
                end else if (paddr == `RFC_STAT_OFF) begin
                    prdata_reg <= {22'h0, units_reg, dp_reg, 1'b0,
                                   under_reg, slow_out_reg, valid_reg};
                end else if (paddr == `RFC_RES_OFF) begin
                    prdata_reg <= {8'h0, quot_reg};
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
            if (psel && penable && pready_reg && pwrite
                && paddr == `RFC_CTRL_OFF) begin
                ctrl_reg <= rfc_pkg::rfc_ctrl_t'(pwdata[`RFC_CTRL_W-1:0]);
            end
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign disp        = rfc_pkg::rfc_result_t'({units_reg, dp_reg,
                                                 quot_reg});
    assign res_valid   = valid_reg;
    assign rec_strobe  = strobe_reg;
    assign slow_active = slow_out_reg;
    assign under_range = under_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_tick_capacity: assert property (cnt_b_reg <= CAP_TICKS)
        else $error("tick register passed capacity");
    a_min_first: assert property (ce && st_reg == rfc_pkg::RFC_COUNT
        && sig_edge && cnt_a_reg == 27'd0 && cnt_b_reg < MIN1_TICKS && !over
        |=> st_reg == rfc_pkg::RFC_COUNT)
        else $error("count ended before least time");
    a_count_cont: assert property (ce && st_reg == rfc_pkg::RFC_COUNT && tick
        && !over |=> cnt_b_reg == $past(cnt_b_reg) + 21'h1)
        else $error("tick lost during count");
    a_range_stable: assert property (st_reg != rfc_pkg::RFC_ROUND
        |=> $stable(dp_reg) && $stable(units_reg))
        else $error("range changed outside division");
    a_auto_slow: assert property (ce && over && !slow
        && ctrl.tb_sel == rfc_pkg::RFC_TB_AUTO |=> auto_slow_reg)
        else $error("no fallback to slow timebase");
    a_force_fast: assert property (ctrl.tb_sel == rfc_pkg::RFC_TB_FAST
        |-> tick == (tb_cnt_reg >= 8'(`RFC_FAST_DIV - 1)))
        else $error("forced fast timebase ignored");
    a_sub_count: assert property (ce && st_reg == rfc_pkg::RFC_SUB
        && !diff[26] |=> digit_reg == $past(digit_reg) + 4'h1
        && st_reg == rfc_pkg::RFC_SUB)
        else $error("digit not incremented");
    a_restore: assert property (ce && st_reg == rfc_pkg::RFC_SUB && diff[26]
        |=> st_reg == rfc_pkg::RFC_ADD ##1 st_reg == rfc_pkg::RFC_MUL
        && cnt_a_reg == $past(cnt_a_reg, 2))
        else $error("remainder not restored");
    a_times_ten: assert property (ce && st_reg == rfc_pkg::RFC_MUL
        |=> cnt_a_reg == 27'($past(cnt_a_reg) * 27'd10))
        else $error("remainder not scaled by ten");
    a_lead_zero: assert property (ce && st_reg == rfc_pkg::RFC_MUL && !rec
        |=> $stable(quot_reg) && norm_reg == $past(norm_reg) + 4'h1)
        else $error("leading zero entered quotient");
    a_strobe_pulse: assert property (rec_strobe |-> valid_reg
        && st_reg == rfc_pkg::RFC_HOLD)
        else $error("recorder strobe without result");

    c_fast_result: cover property (rec_strobe && !slow_run_reg);
    c_slow_result: cover property (rec_strobe && slow_run_reg);
    c_overflow:    cover property (over);
    c_hold_inf:    cover property (st_reg == rfc_pkg::RFC_HOLD
                                   && ctrl.hold_inf);
endmodule : rfc_counter

// File: include/rfc_map.svh
// Offsets, control width, reset values and timing of the counter
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
`define RFC_CTRL_OFF 12'h000
`define RFC_STAT_OFF 12'h004
`define RFC_RES_OFF 12'h008
`define RFC_CTRL_W 17
`define RFC_CTRL_RST 17'h00280
`define RFC_PCLK_MHZ 200
`define RFC_FAST_MHZ 10
`define RFC_SLOW_MHZ 1
`define RFC_FAST_DIV (`RFC_PCLK_MHZ / `RFC_FAST_MHZ)
`define RFC_SLOW_DIV (`RFC_PCLK_MHZ / `RFC_SLOW_MHZ)
`define RFC_CAP_US 167000
`define RFC_MIN1_US 78600
`define RFC_MIN2_US 91800
`define RFC_MIN3_US 98300
`define RFC_MIN4_US 101600
`define RFC_TICKS(us) ((us) * `RFC_FAST_MHZ)
`define RFC_RET_CHZ 788
`define RFC_RET_TICKS ((`RFC_SLOW_MHZ * 100000000) / `RFC_RET_CHZ)
`define RFC_UNIT_MS 10
`define RFC_UNIT_CYC (`RFC_UNIT_MS * 1000 * `RFC_PCLK_MHZ)
`define RFC_DISP_MIN 11'd2
`define RFC_DISP_MAX 11'd1000
`define RFC_LAST_SIG 3'd6
`define RFC_NORM_MAX 4'hF
`define RFC_ROUND_AT 4'd5
`endif

// File: include/rfc_pkg.sv
// Types of the reciprocal frequency counter
package rfc_pkg;
    typedef enum logic [1:0] {
        RFC_TB_AUTO = 2'b00,
        RFC_TB_SLOW = 2'b01,
        RFC_TB_FAST = 2'b10
    } rfc_tb_sel_t;
    typedef enum logic [1:0] {
        RFC_X1   = 2'b00,
        RFC_X10  = 2'b01,
        RFC_X100 = 2'b10
    } rfc_mult_t;
    typedef enum logic [2:0] {
        RFC_IDLE  = 3'b000,
        RFC_ARM   = 3'b001,
        RFC_COUNT = 3'b010,
        RFC_SUB   = 3'b011,
        RFC_ADD   = 3'b100,
        RFC_MUL   = 3'b101,
        RFC_ROUND = 3'b110,
        RFC_HOLD  = 3'b111
    } rfc_state_t;
    typedef struct packed {
        logic [10:0] disp_units;
        logic        hold_inf;
        rfc_mult_t   mult;
        logic        slope;
        rfc_tb_sel_t tb_sel;
    } rfc_ctrl_t;
    typedef struct packed {
        logic [1:0]  units;
        logic [3:0]  dp;
        logic [23:0] digits;
    } rfc_result_t;
endpackage : rfc_pkg

// File: verification/rfc_sig_src.sv
// Signal source standing in for the measured input
`timescale 1ns/10ps
module rfc_sig_src (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Half period in pclk cycles, zero stops the signal
    input  wire logic [15:0] half,
    // Conditioned signal
    output logic             sig
);
    logic [15:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            sig     <= 1'b0;
        end else if (half == 16'h0000) begin
            sig     <= 1'b0;
        end else if (cnt_reg >= half - 16'h0001) begin
            cnt_reg <= 16'h0000;
            sig     <= ~sig;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule : rfc_sig_src

// File: verification/tb.sv
// Self-checking bench of the reciprocal counter
`timescale 1ns/10ps
module tb;
    logic                 pclk, presetn, psel, penable, pwrite, sig_in;
    logic                 pready, pslverr, err, prog_en;
    logic                 res_valid, rec_strobe, slow_active, under_range;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [1:0]           prog_tb_sel, prog_mult;
    logic                 ce, prog_slope, prog_hold_inf;
    logic [15:0]          half;
    rfc_pkg::rfc_result_t disp;
    int                   num_errors, cmp_count, cyc;
    rfc_counter #(.CAP_TICKS(21'd400), .MIN1_TICKS(21'd100),
        .MIN2_TICKS(21'd120), .MIN3_TICKS(21'd130), .MIN4_TICKS(21'd140),
        .RET_TICKS(21'd300), .UNIT_CYC(21'd10)) i_rfc_counter (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sig_in(sig_in),
        .prog_en(prog_en), .prog_tb_sel(prog_tb_sel),
        .prog_slope(prog_slope), .prog_mult(prog_mult),
        .prog_hold_inf(prog_hold_inf), .disp(disp),
        .res_valid(res_valid), .rec_strobe(rec_strobe),
        .slow_active(slow_active), .under_range(under_range));
    rfc_sig_src i_rfc_sig_src (.pclk(pclk), .presetn(presetn), .half(half),
        .sig(sig_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Second result after a change, so the old input no longer counts
    task automatic meas(input logic [15:0] h, input logic [29:0] exp,
                        input logic slow);
        half <= h;
        repeat (2) begin
            @(posedge pclk);
            while (rec_strobe !== 1'b1) @(posedge pclk);
        end
        check(32'(disp), 32'(exp));
        check(32'(slow_active), 32'(slow));
        check(32'(res_valid), 32'h1);
        check(32'(under_range), 32'h0);
    endtask : meas
    // Clock enable low freezes the held result
    task automatic freeze(input logic [29:0] exp);
        ce <= 1'b0;
        repeat (300) @(posedge pclk);
        check(32'(disp), 32'(exp));
        check(32'(res_valid), 32'h1);
        ce <= 1'b1;
        @(posedge pclk);
    endtask : freeze
    ////////////////////////////////////////////////////////////////////////
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 90000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, prog_en} = 6'h00;
        {ce, prog_slope, prog_hold_inf, prog_mult} = 5'h10;
        {paddr, pwdata, prog_tb_sel, half} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0000_0280);
        apb(1'b0, 12'h00C, 32'h0);
        check({rd[30:0], err}, 32'h0000_0001);
        meas(16'h0096, {2'h1, 4'h3, 24'h666667}, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        check(32'(rd[9:0]), 32'h0000_0131);
        apb(1'b1, 12'h000, 32'h0000_0288);
        meas(16'h00C8, {2'h2, 4'h1, 24'h500000}, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0280);
        prog_en <= 1'b1;
        prog_tb_sel <= 2'b01;
        prog_slope <= 1'b1;
        meas(16'h00C8, {2'h1, 4'h3, 24'h500000}, 1'b1);
        freeze({2'h1, 4'h3, 24'h500000});
        close_out();
    end
endmodule : tb
